// ### src/oda_pkg.sv
package oda_pkg;

	// Channel count, bus address width and field widths
	localparam int NCH = 8;
	localparam int AW  = 20;
	localparam int DW  = 32;
	localparam int EVW = 5;
	localparam int CW  = 5;

	// Per-channel register pages; channel Y sits Y strides above channel 0
	localparam logic [19:0] CH0_PAGE      = 20'h6_1000;
	localparam logic [19:0] CH_STRIDE     = 20'h0_1000;
	localparam logic [19:0] REG_CTL_CH0   = 20'h6_1008;
	localparam logic [19:0] REG_FLAG_CH0  = 20'h6_100C;
	localparam logic [19:0] REG_FORCE_CH0 = 20'h6_1010;
	localparam logic [19:0] REG_STS_CH0   = 20'h6_1014;
	localparam logic [19:0] REG_MASK_CH0  = 20'h6_1018;

	// Flag bit positions, shared by flag, force and mask registers
	localparam int BIT_RING_FULL = 4;
	localparam int BIT_LIST_DONE = 3;
	localparam int BIT_SUSP_DONE = 2;
	localparam int BIT_ERROR     = 1;
	localparam int BIT_DESC_IRQ  = 0;

	// Control and status field positions
	localparam int CTL_SUSPEND_BIT = 1;
	localparam int STS_CAUSE_LSB   = 16;

	// Example cause code: excessive message retries
	localparam logic [4:0] CAUSE_MSG_RETRY = 5'h04;

	// Reset values
	localparam logic       FLAG_BIT_RST = 1'h0;
	localparam logic [4:0] MASK_RST     = 5'h01;
	localparam logic [4:0] CAUSE_RST    = 5'h00;
	localparam logic       SUSP_RST     = 1'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Events of one channel, in flag bit order 4..0
	typedef struct packed {
		logic ring_full;
		logic list_done;
		logic suspend_done;
		logic error;
		logic desc_irq_done;
	} oda_evt_t;

	// One accepted register write
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [3:0]    strb;
	} oda_wreq_t;

endpackage

// ### src/oda_flag_cell.sv
`timescale 1ns/1ps
module oda_flag_cell (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	input  wire logic set_evt,
	input  wire logic set_frc,
	input  wire logic clr,
	output logic      flag
);
	import oda_pkg::*;

	// Sticky bit; a set in the clearing cycle must not be lost, so set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag <= FLAG_BIT_RST;
		end else if (ce) begin
			if (set_evt || set_frc) begin
				flag <= 1'h1;
			end else if (clr) begin
				flag <= 1'h0;
			end
		end
	end

endmodule

// ### src/oda_axil_if.sv
`timescale 1ns/1ps
module oda_axil_if (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ce,
	input  wire logic [oda_pkg::AW-1:0]    s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [oda_pkg::DW-1:0]    s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [oda_pkg::AW-1:0]    s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [oda_pkg::DW-1:0]         s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output oda_pkg::oda_wreq_t             wreq,
	output logic                           wr_req,
	input  wire logic                      wr_ok,
	output logic [oda_pkg::AW-1:0]         rd_addr,
	output logic                           rd_req,
	input  wire logic [oda_pkg::DW-1:0]    rd_data,
	input  wire logic                      rd_ok
);
	import oda_pkg::*;

	logic aw_have_r;
	logic w_have_r;

	// Write fires once both halves are held and no response is pending
	assign wr_req = ce && aw_have_r && w_have_r && !s_axi_bvalid;
	assign rd_req = ce && !s_axi_arready && !s_axi_rvalid;

	// Write path; ready drops after a take so one write at a time is in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'h0;
			w_have_r      <= 1'h0;
			s_axi_awready <= 1'h1;
			s_axi_wready  <= 1'h1;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= RESP_OKAY;
			wreq          <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				wreq.addr     <= s_axi_awaddr;
				aw_have_r     <= 1'h1;
				s_axi_awready <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wreq.data    <= s_axi_wdata;
				wreq.strb    <= s_axi_wstrb;
				w_have_r     <= 1'h1;
				s_axi_wready <= 1'h0;
			end
			if (wr_req) begin
				aw_have_r    <= 1'h0;
				w_have_r     <= 1'h0;
				s_axi_bvalid <= 1'h1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready  <= 1'h1;
			end
		end
	end

	// Read path; data is sampled one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			rd_addr       <= '0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rd_addr       <= s_axi_araddr;
				s_axi_arready <= 1'h0;
			end
			if (rd_req) begin
				s_axi_rvalid <= 1'h1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'h0;
				s_axi_arready <= 1'h1;
			end
		end
	end

endmodule

// ### src/oda_top.sv
`timescale 1ns/1ps
module oda_top #(
	parameter int NCH = oda_pkg::NCH
) (
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	input  wire logic                               ce,
	input  wire logic [oda_pkg::AW-1:0]             s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [oda_pkg::DW-1:0]             s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [oda_pkg::AW-1:0]             s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [oda_pkg::DW-1:0]                  s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	input  oda_pkg::oda_evt_t [NCH-1:0]             chan_evt,
	input  wire logic [NCH-1:0][oda_pkg::CW-1:0]    err_cause,
	output logic [NCH-1:0]                          suspend_req,
	output logic [NCH-1:0]                          chan_irq,
	output logic                                    irq
);
	import oda_pkg::*;

	oda_wreq_t              wreq;
	logic                   wr_req;
	logic                   wr_ok;
	logic [AW-1:0]          rd_addr;
	logic                   rd_req;
	logic [DW-1:0]          rd_data;
	logic                   rd_ok;
	logic [AW-1:0]          wrel;
	logic [AW-1:0]          rrel;
	logic                   w_inwin;
	logic                   r_inwin;
	logic [2:0]             wch;
	logic [2:0]             rch;
	logic [11:0]            wpg;
	logic [11:0]            rpg;
	logic                   lane0;
	logic                   w_ctl;
	logic                   w_flag;
	logic                   w_force;
	logic                   w_sts;
	logic                   w_mask;
	logic [NCH-1:0][EVW-1:0] flag;
	logic [NCH-1:0][EVW-1:0] mask_r;
	logic [NCH-1:0][CW-1:0]  cause_r;

	// Bus slave; all AXI outputs are registered inside it
	oda_axil_if u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wreq          (wreq),
		.wr_req        (wr_req),
		.wr_ok         (wr_ok),
		.rd_addr       (rd_addr),
		.rd_req        (rd_req),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	// Address split: channel from the stride field, page offset below it.
	// Addresses under the window wrap to large values and fall outside too.
	assign wrel    = wreq.addr - CH0_PAGE;
	assign rrel    = rd_addr - CH0_PAGE;
	assign w_inwin = (wrel[AW-1:15] == '0) && (32'(wrel[14:12]) < NCH);
	assign r_inwin = (rrel[AW-1:15] == '0) && (32'(rrel[14:12]) < NCH);
	assign wch     = wrel[14:12];
	assign rch     = rrel[14:12];
	assign wpg     = {wrel[11:2], 2'h0};
	assign rpg     = {rrel[11:2], 2'h0};
	assign lane0   = wreq.strb[0];

	// Register select within a channel page
	assign w_ctl   = w_inwin && (wpg == REG_CTL_CH0[11:0]);
	assign w_flag  = w_inwin && (wpg == REG_FLAG_CH0[11:0]);
	assign w_force = w_inwin && (wpg == REG_FORCE_CH0[11:0]);
	assign w_sts   = w_inwin && (wpg == REG_STS_CH0[11:0]);
	assign w_mask  = w_inwin && (wpg == REG_MASK_CH0[11:0]);
	assign wr_ok   = w_ctl || w_flag || w_force || w_sts || w_mask;

	// Per-channel state; channel Y decodes to stride Y
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic           sel;
		logic [EVW-1:0] hw;
		logic [EVW-1:0] clr;
		logic [EVW-1:0] frc;

		// Only byte lane 0 carries the live bits; zeros written to flag or force do nothing
		assign sel = wr_req && lane0 && (wch == 3'(c));
		assign clr = (sel && w_flag) ? wreq.data[EVW-1:0] : '0;
		assign frc = (sel && w_force) ? wreq.data[EVW-1:0] : '0;

		// Hardware events in flag bit order
		assign hw[BIT_RING_FULL] = chan_evt[c].ring_full;
		assign hw[BIT_LIST_DONE] = chan_evt[c].list_done;
		assign hw[BIT_SUSP_DONE] = chan_evt[c].suspend_done;
		assign hw[BIT_ERROR]     = chan_evt[c].error;
		assign hw[BIT_DESC_IRQ]  = chan_evt[c].desc_irq_done;

		// One sticky cell per flag bit; force bits map one to one.
		// Force bits 4..0 cover ring full, list done, suspend, error, descriptor.
		for (genvar b = 0; b < EVW; b++) begin : g_bit
			oda_flag_cell u_cell (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.set_evt (hw[b]),
				.set_frc (frc[b]),
				.clr     (clr[b]),
				.flag    (flag[c][b])
			);
		end

		// Interrupt enable; bit 0 enabled out of reset
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mask_r[c] <= MASK_RST;
			end else if (ce && sel && w_mask) begin
				mask_r[c] <= wreq.data[EVW-1:0];
			end
		end

		// Suspend request; a write in the completion cycle still wins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				suspend_req[c] <= SUSP_RST;
			end else if (ce) begin
				if (sel && w_ctl) begin
					suspend_req[c] <= wreq.data[CTL_SUSPEND_BIT];
				end else if (chan_evt[c].suspend_done) begin
					suspend_req[c] <= 1'h0;
				end
			end
		end

		// Cause follows the latest error; software cannot alter it here
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cause_r[c] <= CAUSE_RST;
			end else if (ce && chan_evt[c].error) begin
				cause_r[c] <= err_cause[c];
			end
		end

		// Channel request, one cycle behind the flags it reflects
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				chan_irq[c] <= 1'h0;
			end else if (ce) begin
				chan_irq[c] <= |(flag[c] & mask_r[c]);
			end
		end
	end

	// Combined level interrupt from every unmasked flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'h0;
		end else if (ce) begin
			irq <= |(flag & mask_r);
		end
	end

	// Read mux; force reads as zero since its bits are pulses, not state
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = r_inwin;
		if (r_inwin) begin
			case (rpg)
				REG_CTL_CH0[11:0]: begin
					rd_data[CTL_SUSPEND_BIT] = suspend_req[rch];
				end
				REG_FLAG_CH0[11:0]: begin
					rd_data[EVW-1:0] = flag[rch];
				end
				REG_FORCE_CH0[11:0]: begin
					rd_data = 32'h0000_0000;
				end
				REG_STS_CH0[11:0]: begin
					rd_data[STS_CAUSE_LSB +: CW] = cause_r[rch];
				end
				REG_MASK_CH0[11:0]: begin
					rd_data[EVW-1:0] = mask_r[rch];
				end
				default: begin
					rd_ok = 1'h0;
				end
			endcase
		end
	end

endmodule

// ### sim/oda_top_props.sv
`timescale 1ns/1ps
module oda_top_props #(
	parameter int NCH = oda_pkg::NCH
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	input  wire logic                         s_axi_awvalid,
	input  wire logic                         s_axi_awready,
	input  wire logic                         s_axi_wvalid,
	input  wire logic                         s_axi_wready,
	input  wire logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic                         s_axi_arvalid,
	input  wire logic                         s_axi_arready,
	input  wire logic [oda_pkg::DW-1:0]       s_axi_rdata,
	input  wire logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  oda_pkg::oda_evt_t [NCH-1:0]       chan_evt,
	input  wire logic [NCH-1:0]               suspend_req,
	input  wire logic [NCH-1:0]               chan_irq,
	input  wire logic                         irq
);
	import oda_pkg::*;

	// One clock domain, so one default clock and reset
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Write answer two edges after both halves are taken together; the
	// register effect and bvalid both land on the middle edge, bvalid is seen on the next
	property p_b_answer;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer missing");
	property p_b_stand;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
	// Second write must not slip in while the answer waits
	property p_ready_low;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready while answer pending");
	// Read data comes from the latched address, so rvalid follows two edges on
	property p_r_answer;
		ce && s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer missing");
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data moved");
	// Channel 0 keeps enable bit 0 from reset, so an event must reach the output
	property p_evt_irq;
		(ce && chan_evt[0].desc_irq_done) ##1 ce |=> chan_irq[0];
	endproperty
	a_evt_irq: assert property (p_evt_irq) else $error("event gave no interrupt");
	property p_susp_clr;
		ce && chan_evt[0].suspend_done |=> !suspend_req[0];
	endproperty
	a_susp_clr: assert property (p_susp_clr) else $error("suspend request stuck");
	property p_irq_or;
		irq == (|chan_irq);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("summary interrupt wrong");
endmodule

// ### sim/oda_top_tb_top.sv
`timescale 1ns/1ps
module oda_top_tb_top;
	import oda_pkg::*;
	logic                    aclk, aresetn, ce, irq;
	logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                    s_axi_rvalid, s_axi_rready;
	logic [AW-1:0]           s_axi_awaddr, s_axi_araddr;
	logic [DW-1:0]           s_axi_wdata, s_axi_rdata;
	logic [3:0]              s_axi_wstrb;
	logic [1:0]              s_axi_bresp, s_axi_rresp, r;
	oda_evt_t [NCH-1:0]      chan_evt;
	logic [NCH-1:0][CW-1:0]  err_cause;
	logic [NCH-1:0]          suspend_req, chan_irq;
	int                      errors = 0, checks = 0, cyc = 0;

	oda_top #(.NCH(NCH)) i_oda_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.chan_evt, .err_cause, .suspend_req, .chan_irq, .irq);

	// 25 ns period
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic wrok(input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [1:0] rs;
		wr(a, d, rs);
		chk("bresp", RESP_OKAY, rs);
	endtask

	task automatic rdchk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] e);
		logic [DW-1:0] d;
		logic [1:0]    rs;
		rd(a, d, rs);
		chk(n, e, d);
		chk("rresp", RESP_OKAY, rs);
	endtask

	// One-cycle event pulse on one channel
	task automatic pulse(input int c, input int b);
		@(posedge aclk);
		chan_evt[c] <= oda_evt_t'(5'(1 << b));
		@(posedge aclk);
		chan_evt[c] <= '0;
	endtask

	function automatic logic [AW-1:0] fa(input logic [AW-1:0] base, input int c);
		return base + AW'(c) * CH_STRIDE;
	endfunction

	initial begin
		logic [DW-1:0] d;
		ce = 1'h1;
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		chan_evt = '0;
		err_cause = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		// Flag and force reset values of every channel
		for (int c = 0; c < NCH; c++) begin
			rdchk("flag reset", fa(REG_FLAG_CH0, c), '0);
			rdchk("force reset", fa(REG_FORCE_CH0, c), '0);
		end
		// Force each bit on its own channel; zeros written must not clear
		for (int b = 0; b < EVW; b++) begin
			wrok(fa(REG_FORCE_CH0, b + 2), 32'h1 << b);
			rdchk("forced flag", fa(REG_FLAG_CH0, b + 2), 32'h1 << b);
			rdchk("neighbour flag", fa(REG_FLAG_CH0, b + 3), '0);
			rdchk("force readback", fa(REG_FORCE_CH0, b + 2), '0);
			wrok(fa(REG_FLAG_CH0, b + 2), ~(32'h1 << b));
			rdchk("zero write kept", fa(REG_FLAG_CH0, b + 2), 32'h1 << b);
			wrok(fa(REG_FLAG_CH0, b + 2), 32'h1 << b);
			rdchk("flag cleared", fa(REG_FLAG_CH0, b + 2), '0);
		end
		wrok(fa(REG_FORCE_CH0, 7), 32'hFFFF_FFFF);
		rdchk("reserved bits", fa(REG_FLAG_CH0, 7), 32'h0000_001F);
		wrok(fa(REG_FLAG_CH0, 7), 32'hFFFF_FFFF);
		rdchk("all cleared", fa(REG_FLAG_CH0, 7), '0);
		// Real events, each bit in turn
		for (int b = 0; b < EVW; b++) begin
			pulse(5, b);
			rdchk("event flag", fa(REG_FLAG_CH0, 5), 32'h1 << b);
			wrok(fa(REG_FLAG_CH0, 5), 32'h1 << b);
		end
		// Error with its cause code
		@(posedge aclk);
		err_cause[2] <= CAUSE_MSG_RETRY;
		pulse(2, BIT_ERROR);
		rdchk("error flag", fa(REG_FLAG_CH0, 2), 32'h0000_0002);
		rdchk("error cause", fa(REG_STS_CH0, 2), {11'h0, CAUSE_MSG_RETRY, 16'h0});
		// Interrupt raised, masked, unmasked and cleared
		pulse(0, BIT_DESC_IRQ);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h1, 32'(irq));
		chk("chan irq", 32'h0000_0001, 32'(chan_irq));
		wrok(fa(REG_MASK_CH0, 0), '0);
		repeat (2) @(posedge aclk);
		chk("irq masked", '0, 32'(irq));
		wrok(fa(REG_MASK_CH0, 0), 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk("irq unmasked", 32'h1, 32'(irq));
		wrok(fa(REG_FLAG_CH0, 0), 32'h0000_0001);
		pulse(0, BIT_ERROR);
		repeat (2) @(posedge aclk);
		chk("irq disabled bit", '0, 32'(irq));
		wrok(fa(REG_FLAG_CH0, 0), 32'h0000_0002);
		// Suspend request clears itself with the completion flag
		wrok(fa(REG_CTL_CH0, 0), 32'h0000_0002);
		chk("suspend req", 32'h1, 32'(suspend_req));
		pulse(0, BIT_SUSP_DONE);
		rdchk("suspend auto clear", fa(REG_CTL_CH0, 0), '0);
		rdchk("suspend flag", fa(REG_FLAG_CH0, 0), 32'h0000_0004);
		// Unmapped places are refused
		wr(20'h0_0000, 32'h0000_0001, r);
		chk("unmapped bresp", RESP_SLVERR, r);
		rd(20'h6_1004, d, r);
		chk("unmapped rresp", RESP_SLVERR, r);
		chk("unmapped rdata", '0, d);
		// Lane 0 strobe low: write answered but ignored
		s_axi_wstrb <= 4'hE;
		wrok(fa(REG_FORCE_CH0, 1), 32'h0000_0001);
		s_axi_wstrb <= 4'hF;
		rdchk("strobe off flag", fa(REG_FLAG_CH0, 1), '0);
		// Clock enable low freezes the flags against events
		ce <= 1'h0;
		pulse(1, BIT_LIST_DONE);
		@(posedge aclk);
		ce <= 1'h1;
		rdchk("frozen flag", fa(REG_FLAG_CH0, 1), '0);
		pulse(1, BIT_LIST_DONE);
		rdchk("running flag", fa(REG_FLAG_CH0, 1), 32'h0000_0008);
		report_and_stop();
	end
endmodule

bind oda_top oda_top_props #(.NCH(NCH)) i_oda_top_props (.aclk, .aresetn, .ce, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.chan_evt, .suspend_req, .chan_irq, .irq);
